// >>> verilog/fault_supervisor.sv
// line overvoltage, brown-in/out and thermal fault supervisor
// Behaviour
// R1: stop switching after filtered line overvoltage
// R2: recycle supply via startup source during overvoltage
// R3: resume switching once overvoltage clears
// R4: overvoltage filter is saturating up/down counter
// R5: grounded overvoltage sense disables function
// R6: source strap test current while supply charges
// R7: low strap level disables brown logic, latched
// R8: fixed start window, then require above drop
// R9: brown-in after filtered rise above level
// R10: brown-out after filtered drop below level
// R11: brown filters are up/down counters
// R12: 10 kHz 5 percent jitter wave
// R13: overtemp off fixed time, restart at turn-on
// R14: recycle supply, low fault current while overtemp
// R15: enable only with no fault and start met
// R16: debounce counters saturate, clear on reset
`timescale 1ns/1ps
`default_nettype none
module fault_supervisor #(
  parameter int LINE_OV_CNT = fault_supervisor_pkg::LINE_OV_CYCLES,
  parameter int LINE_RISE_CNT = fault_supervisor_pkg::LINE_RISE_CYCLES,
  parameter int LINE_DROP_CNT = fault_supervisor_pkg::LINE_DROP_CYCLES,
  parameter int START_WINDOW_CNT = fault_supervisor_pkg::START_WINDOW_CYCLES,
  parameter int OVERTEMP_OFF_CNT = fault_supervisor_pkg::OVERTEMP_OFF_CYCLES,
  parameter int JITTER_HALF_CNT = fault_supervisor_pkg::JITTER_HALF_CYCLES
) (
  // clock and reset
  input wire logic clk_i,
  input wire logic reset_i,
  // comparator results
  input wire fault_supervisor_pkg::sense_s sense_i,
  // drives to power stage and supply
  output fault_supervisor_pkg::drive_s drive_o,
  // status
  output logic line_ov_fault_o,
  output logic brown_disabled_o
);
  localparam int TW = $clog2(OVERTEMP_OFF_CNT + START_WINDOW_CNT + 1);
  localparam int JW = $clog2(JITTER_HALF_CNT + 1);
  localparam logic [TW-1:0] WIN_END = TW'(START_WINDOW_CNT - 1);
  localparam logic [TW-1:0] OT_END = TW'(OVERTEMP_OFF_CNT - 1);
  localparam logic [JW-1:0] JIT_END = JW'(JITTER_HALF_CNT - 1);

  fault_supervisor_pkg::sup_state_e state_q;
  logic [TW-1:0] timer_q;
  logic [JW-1:0] jit_cnt_q;
  logic jitter_q;
  logic strap_q;
  logic ov_fault_q;
  logic ov_hit, rise_hit, drop_hit;
  logic run_ok;

  // ----------------------------------------------------------------------
  // debounce filters
  // ----------------------------------------------------------------------
  updown_filter #(.TERMINAL(LINE_OV_CNT)) u_ov (
    .clk_i(clk_i),
    .reset_i(reset_i),
    .clear_i(1'b0),
    .up_i(sense_i.line_overvoltage), // R5
    .hit_o(ov_hit),
    .zero_o()
  );
  updown_filter #(.TERMINAL(LINE_RISE_CNT)) u_rise (
    .clk_i(clk_i),
    .reset_i(reset_i),
    .clear_i(state_q != fault_supervisor_pkg::SUP_LINE_LOW),
    .up_i(sense_i.line_above_rise),
    .hit_o(rise_hit),
    .zero_o()
  );
  updown_filter #(.TERMINAL(LINE_DROP_CNT)) u_drop (
    .clk_i(clk_i),
    .reset_i(reset_i),
    .clear_i(state_q != fault_supervisor_pkg::SUP_RUN),
    .up_i(!sense_i.line_above_drop),
    .hit_o(drop_hit),
    .zero_o()
  );

  // ----------------------------------------------------------------------
  // line overvoltage fault
  // ----------------------------------------------------------------------
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      ov_fault_q <= 1'b0;
    end else if (ov_hit) begin
      ov_fault_q <= 1'b1; // R1
    end else if (!sense_i.line_overvoltage && ov_fault_q) begin
      ov_fault_q <= 1'b0; // R3
    end
  end

  // ----------------------------------------------------------------------
  // strap latch
  // ----------------------------------------------------------------------
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      strap_q <= 1'b0;
    end else if (state_q == fault_supervisor_pkg::SUP_CHARGE && sense_i.supply_at_turn_on) begin
      strap_q <= sense_i.line_below_strap; // R7
    end
  end

  // ----------------------------------------------------------------------
  // supervisor sequence
  // ----------------------------------------------------------------------
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      state_q <= fault_supervisor_pkg::SUP_CHARGE;
      timer_q <= '0;
    end else if (sense_i.overtemp && state_q != fault_supervisor_pkg::SUP_OT_OFF) begin
      state_q <= fault_supervisor_pkg::SUP_OT_OFF; // R13
      timer_q <= '0;
    end else begin
      case (state_q)
        fault_supervisor_pkg::SUP_CHARGE: begin
          timer_q <= '0;
          if (sense_i.supply_at_turn_on) begin
            if (sense_i.line_below_strap) begin
              state_q <= fault_supervisor_pkg::SUP_RUN; // R7
            end else begin
              state_q <= fault_supervisor_pkg::SUP_WINDOW; // R8
            end
          end
        end
        fault_supervisor_pkg::SUP_WINDOW: begin
          timer_q <= timer_q + 1'b1;
          if (timer_q == WIN_END) begin
            timer_q <= '0;
            if (sense_i.line_above_drop) begin
              state_q <= fault_supervisor_pkg::SUP_RUN; // R8
            end else begin
              state_q <= fault_supervisor_pkg::SUP_LINE_LOW; // R8
            end
          end
        end
        fault_supervisor_pkg::SUP_RUN: begin
          if (!strap_q && drop_hit) begin
            state_q <= fault_supervisor_pkg::SUP_LINE_LOW; // R10
          end
        end
        fault_supervisor_pkg::SUP_LINE_LOW: begin
          if (rise_hit) begin
            state_q <= fault_supervisor_pkg::SUP_RUN; // R9
          end
        end
        fault_supervisor_pkg::SUP_OT_OFF: begin
          if (timer_q == OT_END) begin
            timer_q <= '0;
            if (!sense_i.overtemp) begin
              state_q <= fault_supervisor_pkg::SUP_OT_WAIT; // R13
            end
          end else begin
            timer_q <= timer_q + 1'b1;
          end
        end
        fault_supervisor_pkg::SUP_OT_WAIT: begin
          if (sense_i.supply_at_turn_on) begin
            state_q <= fault_supervisor_pkg::SUP_RUN; // R13
          end
        end
        default: begin
          state_q <= fault_supervisor_pkg::SUP_CHARGE;
          timer_q <= '0;
        end
      endcase
    end
  end

  // ----------------------------------------------------------------------
  // jitter wave
  // ----------------------------------------------------------------------
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      jit_cnt_q <= '0;
      jitter_q <= 1'b0;
    end else if (jit_cnt_q == JIT_END) begin
      jit_cnt_q <= '0;
      jitter_q <= !jitter_q; // R12
    end else begin
      jit_cnt_q <= jit_cnt_q + 1'b1;
    end
  end

  // ----------------------------------------------------------------------
  // output drive
  // ----------------------------------------------------------------------
  assign run_ok = (state_q == fault_supervisor_pkg::SUP_WINDOW ||
                   state_q == fault_supervisor_pkg::SUP_RUN) && !sense_i.overtemp;

  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      drive_o <= '0;
      line_ov_fault_o <= 1'b0;
      brown_disabled_o <= 1'b0;
    end else begin
      drive_o.switching_enable <= run_ok && !ov_fault_q && !ov_hit; // R15
      drive_o.startup_current_source <= !sense_i.supply_at_turn_on &&
        (ov_fault_q || state_q != fault_supervisor_pkg::SUP_RUN); // R2 R14
      drive_o.strap_test_current <= (state_q == fault_supervisor_pkg::SUP_CHARGE); // R6
      drive_o.fault_supply_current <= (state_q == fault_supervisor_pkg::SUP_OT_OFF); // R14
      drive_o.jitter_wave <= jitter_q; // R12
      line_ov_fault_o <= ov_fault_q;
      brown_disabled_o <= strap_q;
    end
  end

  // ----------------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------------
  chk_ov_stops_switch: assert property (@(posedge clk_i) disable iff (reset_i) // R1
    ov_fault_q |=> !drive_o.switching_enable) else $error("switching during line overvoltage");
  chk_ov_needs_filter: assert property (@(posedge clk_i) disable iff (reset_i) // R4
    $rose(ov_fault_q) |-> $past(ov_hit)) else $error("overvoltage fault without full count");
  chk_ov_clears: assert property (@(posedge clk_i) disable iff (reset_i) // R3
    (ov_fault_q && !ov_hit && !sense_i.line_overvoltage) |=> !ov_fault_q)
    else $error("overvoltage fault did not clear");
  chk_strap_test_src: assert property (@(posedge clk_i) disable iff (reset_i) // R6
    (state_q == fault_supervisor_pkg::SUP_CHARGE) |=> drive_o.strap_test_current)
    else $error("no strap test current while charging");
  chk_window_length: assert property (@(posedge clk_i) disable iff (reset_i) // R8
    (state_q == fault_supervisor_pkg::SUP_WINDOW) |-> timer_q <= WIN_END)
    else $error("start window overran");
  chk_brown_in: assert property (@(posedge clk_i) disable iff (reset_i) // R9
    (state_q == fault_supervisor_pkg::SUP_LINE_LOW && rise_hit && !sense_i.overtemp)
    |=> state_q == fault_supervisor_pkg::SUP_RUN) else $error("brown-in not taken");
  chk_brown_out: assert property (@(posedge clk_i) disable iff (reset_i) // R10
    (state_q == fault_supervisor_pkg::SUP_RUN && drop_hit && !strap_q && !sense_i.overtemp)
    |=> state_q == fault_supervisor_pkg::SUP_LINE_LOW) else $error("brown-out not taken");
  chk_overtemp_off: assert property (@(posedge clk_i) disable iff (reset_i) // R13
    sense_i.overtemp |=> ##1 !drive_o.switching_enable) else $error("switching in overtemp");
  chk_fault_current: assert property (@(posedge clk_i) disable iff (reset_i) // R14
    (state_q == fault_supervisor_pkg::SUP_OT_OFF) |=> drive_o.fault_supply_current)
    else $error("fault current not selected");
  chk_jitter_period: assert property (@(posedge clk_i) disable iff (reset_i) // R12
    $changed(jitter_q) |=> $stable(jitter_q)) else $error("jitter wave too fast");
endmodule
`default_nettype wire

// >>> verilog/fault_supervisor_pkg.sv
// shared constants and carrier types for the line and thermal fault supervisor
package fault_supervisor_pkg;

  // ----------------------------------------------------------------------
  // timing
  // ----------------------------------------------------------------------
  localparam int CLK_HZ = 50000000;
  localparam int LINE_OV_FILTER_US = 250;
  localparam int LINE_RISE_FILTER_US = 250;
  localparam int LINE_DROP_FILTER_MS = 30;
  localparam int START_WINDOW_MS = 30;
  localparam int OVERTEMP_OFF_MS = 2000;
  localparam int JITTER_HZ = 10000;
  localparam int LINE_OV_CYCLES = (CLK_HZ / 1000000) * LINE_OV_FILTER_US;
  localparam int LINE_RISE_CYCLES = (CLK_HZ / 1000000) * LINE_RISE_FILTER_US;
  localparam int LINE_DROP_CYCLES = (CLK_HZ / 1000) * LINE_DROP_FILTER_MS;
  localparam int START_WINDOW_CYCLES = (CLK_HZ / 1000) * START_WINDOW_MS;
  localparam int OVERTEMP_OFF_CYCLES = (CLK_HZ / 1000) * OVERTEMP_OFF_MS;
  localparam int JITTER_HALF_CYCLES = CLK_HZ / (2 * JITTER_HZ);
  localparam int JITTER_DEPTH_PCT = 5;

  // ----------------------------------------------------------------------
  // carriers
  // ----------------------------------------------------------------------
  typedef struct packed {
    logic line_overvoltage;
    logic line_above_rise;
    logic line_above_drop;
    logic line_below_strap;
    logic overtemp;
    logic supply_at_turn_on;
  } sense_s;

  typedef struct packed {
    logic switching_enable;
    logic startup_current_source;
    logic strap_test_current;
    logic fault_supply_current;
    logic jitter_wave;
  } drive_s;

  // ----------------------------------------------------------------------
  // supervisor states
  // ----------------------------------------------------------------------
  typedef enum logic [5:0] {
    SUP_CHARGE = 6'b000001,
    SUP_WINDOW = 6'b000010,
    SUP_RUN = 6'b000100,
    SUP_LINE_LOW = 6'b001000,
    SUP_OT_OFF = 6'b010000,
    SUP_OT_WAIT = 6'b100000
  } sup_state_e;

endpackage

// >>> verilog/updown_filter.sv
// saturating up/down debounce counter
`timescale 1ns/1ps
`default_nettype none
module updown_filter #(
  parameter int TERMINAL = 12500,
  parameter int W = $clog2(TERMINAL + 1)
) (
  // clock and reset
  input wire logic clk_i,
  input wire logic reset_i,
  // control
  input wire logic clear_i,
  input wire logic up_i,
  // result
  output logic hit_o,
  output logic zero_o
);
  localparam logic [W-1:0] TOP = W'(TERMINAL);
  logic [W-1:0] count_q;

  // ----------------------------------------------------------------------
  // counter
  // ----------------------------------------------------------------------
  always_ff @(posedge clk_i) begin
    if (reset_i || clear_i) begin
      count_q <= '0; // R16
    end else if (up_i && count_q != TOP) begin
      count_q <= count_q + 1'b1; // R4
    end else if (!up_i && count_q != '0) begin
      count_q <= count_q - 1'b1; // R11
    end
  end

  assign hit_o = (count_q == TOP);
  assign zero_o = (count_q == '0);

  chk_count_saturates: assert property (@(posedge clk_i) disable iff (reset_i) // R16
    count_q <= TOP) else $error("filter count beyond terminal");
endmodule
`default_nettype wire

// >>> verif/supply_model.sv
// behavioural model of line dividers, temperature sense and supply capacitor
`timescale 1ns/1ps
`default_nettype none
module supply_model #(
  parameter int CHARGE_CNT = 10
) (
  // clock and reset
  input wire logic clk_i,
  input wire logic reset_i,
  // commanded line level (0 grounded .. 3 above rise), overvoltage, heat
  input wire logic [1:0] line_level_i,
  input wire logic ov_i,
  input wire logic hot_i,
  // device side
  input wire fault_supervisor_pkg::drive_s drive_i,
  output fault_supervisor_pkg::sense_s sense_o
);
  int vdd_q;
  // ----------------------------------------------------------------------
  // supply capacitor: charged by startup source, held while switching
  // ----------------------------------------------------------------------
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      vdd_q <= 0;
    end else if (drive_i.startup_current_source && vdd_q < CHARGE_CNT) begin
      vdd_q <= vdd_q + 1;
    end else if (!drive_i.switching_enable && !drive_i.startup_current_source && vdd_q > 0) begin
      vdd_q <= vdd_q - 1;
    end
  end
  // ----------------------------------------------------------------------
  // comparators
  // ----------------------------------------------------------------------
  always_comb begin
    sense_o.line_overvoltage = ov_i;
    sense_o.line_above_rise = (line_level_i == 2'h3);
    sense_o.line_above_drop = (line_level_i >= 2'h2);
    sense_o.line_below_strap = (line_level_i == 2'h0) || !drive_i.strap_test_current;
    sense_o.overtemp = hot_i;
    sense_o.supply_at_turn_on = (vdd_q >= CHARGE_CNT);
  end
endmodule
`default_nettype wire

// >>> verif/tb_top.sv
// self-checking bench for the fault supervisor
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  localparam int OV = 8;
  localparam int RISE = 8;
  localparam int DROP = 20;
  localparam int WIN = 30;
  localparam int OT = 40;
  localparam int JIT = 4;
  logic clk_i = 1'b0;
  logic reset_i = 1'b1;
  logic [1:0] line_level = 2'h0;
  logic ov = 1'b0;
  logic hot = 1'b0;
  logic j;
  fault_supervisor_pkg::sense_s sense;
  fault_supervisor_pkg::drive_s drive;
  logic line_ov_fault;
  logic brown_disabled;
  int fail_count = 0;
  int compares = 0;
  int n;

  always #10 clk_i = ~clk_i;

  fault_supervisor #(.LINE_OV_CNT(OV), .LINE_RISE_CNT(RISE), .LINE_DROP_CNT(DROP),
    .START_WINDOW_CNT(WIN), .OVERTEMP_OFF_CNT(OT), .JITTER_HALF_CNT(JIT)) i_fault_supervisor (
    .clk_i(clk_i), .reset_i(reset_i), .sense_i(sense), .drive_o(drive),
    .line_ov_fault_o(line_ov_fault), .brown_disabled_o(brown_disabled));

  supply_model i_supply_model (.clk_i(clk_i), .reset_i(reset_i), .line_level_i(line_level),
    .ov_i(ov), .hot_i(hot), .drive_i(drive), .sense_o(sense));

  function automatic logic ov_expected(input int high_cycles);
    return high_cycles > OV;
  endfunction

  task automatic chk(input string what, input logic seen, input logic exp);
    compares++;
    if (seen !== exp) begin
      fail_count++;
      $display("CHECK FAILED %s expected %b seen %b", what, exp, seen);
    end
  endtask

  task automatic tick(input int k);
    repeat (k) @(posedge clk_i);
    #2;
  endtask

  task automatic wait_en(input logic v, input int cap, output int cnt);
    cnt = 0;
    while (drive.switching_enable !== v && cnt < cap) begin
      tick(1);
      cnt++;
    end
  endtask

  task automatic do_reset(input logic [1:0] lvl);
    reset_i = 1'b1;
    line_level = lvl;
    tick(20);
    chk("outputs at reset", drive === '0 && line_ov_fault === 1'b0, 1'b1);
    chk("status at reset", brown_disabled, 1'b0);
    reset_i = 1'b0;
  endtask

  task automatic results();
    $display("compares %0d fail_count %0d", compares, fail_count);
    if (fail_count == 0 && compares > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  initial begin
    #200000;
    fail_count++;
    results();
  end

  initial begin
    void'($urandom(32'h60d7));
    do_reset(2'h0);
    tick(2);
    chk("strap current", drive.strap_test_current, 1'b1);
    wait_en(1'b1, 100, n);
    chk("strapped start", drive.switching_enable, 1'b1);
    chk("brown disabled", brown_disabled, 1'b1);
    line_level = 2'h1;
    tick(DROP + WIN + 5);
    chk("strap latched", drive.switching_enable, 1'b1);
    $display("test strap done");
    repeat (20) begin
      ov = 1'b1;
      tick($urandom_range(3, 1));
      ov = 1'b0;
      tick($urandom_range(6, 4));
      chk("glitch ignored", line_ov_fault, 1'b0);
    end
    ov = 1'b1;
    tick(OV - 2);
    chk("ov early", line_ov_fault, ov_expected(OV - 2));
    chk("enable early", drive.switching_enable, 1'b1);
    tick(6);
    chk("ov fault", line_ov_fault, ov_expected(OV + 4));
    chk("ov stop", drive.switching_enable, 1'b0);
    n = 0;
    while (drive.startup_current_source !== 1'b1 && n < 40) begin
      tick(1);
      n++;
    end
    chk("ov recharge", drive.startup_current_source, 1'b1);
    ov = 1'b0;
    wait_en(1'b1, 4, n);
    chk("ov resume", drive.switching_enable, 1'b1);
    $display("test overvoltage done");
    for (int k = 0; k < 2; k++) begin
      j = drive.jitter_wave;
      n = 0;
      while (drive.jitter_wave === j && n < 20) begin
        tick(1);
        n++;
      end
    end
    chk("jitter half period", n == JIT, 1'b1);
    $display("test jitter done");
    do_reset(2'h3);
    wait_en(1'b1, 50, n);
    chk("brown enabled", brown_disabled, 1'b0);
    line_level = 2'h1;
    tick(WIN - 10);
    chk("window forced on", drive.switching_enable, 1'b1);
    wait_en(1'b0, 20, n);
    chk("window low line", drive.switching_enable, 1'b0);
    chk("window length", n == 10, 1'b1);
    line_level = 2'h2;
    tick(RISE + 5);
    chk("below rise stays off", drive.switching_enable, 1'b0);
    line_level = 2'h3;
    tick(RISE - 3);
    chk("rise filtered", drive.switching_enable, 1'b0);
    wait_en(1'b1, 10, n);
    chk("brown in", drive.switching_enable, 1'b1);
    line_level = 2'h1;
    tick(DROP / 2);
    line_level = 2'h3;
    tick(DROP);
    chk("drop glitch", drive.switching_enable, 1'b1);
    line_level = 2'h1;
    tick(DROP - 3);
    chk("drop filtered", drive.switching_enable, 1'b1);
    wait_en(1'b0, 10, n);
    chk("brown out", drive.switching_enable, 1'b0);
    line_level = 2'h3;
    wait_en(1'b1, RISE + 10, n);
    $display("test brown done");
    hot = 1'b1;
    tick(2);
    hot = 1'b0;
    tick(2);
    chk("overtemp stop", drive.switching_enable, 1'b0);
    chk("fault current", drive.fault_supply_current, 1'b1);
    wait_en(1'b1, OT + 60, n);
    chk("off time", n >= OT - 4, 1'b1);
    chk("overtemp restart", drive.switching_enable, 1'b1);
    $display("test overtemp done");
    results();
  end
endmodule
`default_nettype wire
